// ---- design/rsc_clk_watch.v ----
`timescale 1ns/1ps
`include "rsc_defs.vh"
// Clock-loss detector: watches a sampled clock level for a stuck period.
// The sampling clock must come from a free-running reference; sampling the
// system clock with itself would never see it stop.
module rsc_clk_watch (
   input  wire ref_clk_i,
   input  wire rst_i,
   input  wire enable_i,
   input  wire clk_level_i,
   output reg  timeout_o
);
   localparam CW = 17;
   localparam [CW-1:0] LIMIT = `RSC_CLKLOSS_CYC;

   reg          last_q;
   reg [CW-1:0] cnt_q;

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         last_q    <= 1'b0;
         cnt_q     <= {CW{1'b0}};
         timeout_o <= 1'b0;
      end else begin
         last_q <= clk_level_i;
         if (!enable_i || clk_level_i != last_q) begin
            cnt_q     <= {CW{1'b0}};
            timeout_o <= 1'b0;
         end else if (cnt_q >= LIMIT) begin
            timeout_o <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end
endmodule // rsc_clk_watch

// ---- design/rsc_defs.vh ----
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH
// Special-function register addresses
`define RSC_ADDR_CAUSE     8'hef
`define RSC_ADDR_MONCTL    8'hff
// reset_cause_and_enable bit positions
`define RSC_B_PIN          0
`define RSC_B_POWER        1
`define RSC_B_CLKLOSS      2
`define RSC_B_WDOG         3
`define RSC_B_SOFT         4
`define RSC_B_COMP         5
`define RSC_B_FLASH        6
// supply_monitor_control bit positions
`define RSC_B_MON_ON       7
`define RSC_B_MON_ABOVE    6
// Reset values
`define RSC_MON_ON_RST     1'b1
`define RSC_EN_RST         4'h0
// Highest user code address
`define RSC_CODE_TOP       16'h7bff
// Timing: clock period in ps, clock-loss timeout in ns
`define RSC_CLK_PS         20000
`define RSC_CLKLOSS_NS     100000
`define RSC_CLKLOSS_CYC    ((`RSC_CLKLOSS_NS * 1000) / `RSC_CLK_PS)
`define RSC_WDOG_DIV       12
// Cycles the core is held after a reset source releases
`define RSC_HOLD_CYC       8
// Cause codes
`define RSC_C_NONE         3'd0
`define RSC_C_PIN          3'd1
`define RSC_C_POWER        3'd2
`define RSC_C_CLKLOSS      3'd3
`define RSC_C_COMP         3'd4
`define RSC_C_WDOG         3'd5
`define RSC_C_FLASH        3'd6
`define RSC_C_SOFT         3'd7
`endif

// ---- design/rsc_reset_ctl.v ----
// Functional notes
// - Supply below threshold drives reset pin low and holds core until it recovers.
// - Monitor enable set only by power-on; other resets leave it unchanged.
// - Supply monitor resets only when enabled and selected via power-on bit.
// - Monitor control: bit7 enable, bit6 supply status, bits 5-0 reserved.
// - Low on reset pin resets device; pin flag set on exit.
// - Enabled clock-loss detector resets after clock stuck over 100 us.
// - Bit 2 writes clock-loss enable; reads one only after clock-loss reset.
// - Bit 5 selects comparator; reset while plus below minus; flag after.
// - Watchdog enabled after reset at clock/12; timeout resets, sets bit 3.
// - Out-of-range flash write, code read, branch or security block resets.
// - Flash write with monitor off resets; bit 6 flags flash errors.
// - Writing one to bit 4 forces reset and reads one after; zero ignored.
// - Internal-only resets leave the external reset pin undriven.
// - Read-modify-write reads stored enables of dual-purpose bits, not flags.
// - Bit 1 set on power-on or monitor reset; write selects monitor.
// - Bit 7 of the cause register reads zero; writes ignored.
// - Any reset other than power-on or monitor clears the power-on flag.
// - In reset, core halts; on exit executes from address zero.
`timescale 1ns/1ps
`include "rsc_defs.vh"
module rsc_reset_ctl (
   input  wire        ref_clk_i,
   input  wire        rst_i,
   input  wire        por_n_i,
   input  wire        rst_pin_n_i,
   output reg         rst_pin_o,
   output reg         rst_pin_oe_o,
   input  wire        supply_above_i,
   output reg         supply_monitor_on_o,
   input  wire        comparator_out_i,
   input  wire        clk_level_i,
   input  wire        wdog_kick_i,
   input  wire        wdog_on_i,
   input  wire [15:0] wdog_limit_i,
   input  wire        flash_wr_i,
   input  wire        program_store_write_on_i,
   input  wire [15:0] flash_addr_i,
   input  wire        code_memory_read_i,
   input  wire [15:0] code_addr_i,
   input  wire        branch_i,
   input  wire [15:0] branch_addr_i,
   input  wire        security_block_i,
   input  wire        sfr_wr_i,
   input  wire        sfr_rd_i,
   input  wire        sfr_rmw_i,
   input  wire [7:0]  sfr_addr_i,
   input  wire [7:0]  sfr_wdata_i,
   output reg  [7:0]  sfr_rdata_o,
   output reg         core_rst_o,
   output reg         pc_clear_o,
   output reg         wdog_tick_o
);
   localparam ST_RUN  = 3'b001;
   localparam ST_HOLD = 3'b010;
   localparam ST_EXIT = 3'b100;
   localparam [3:0] HOLD_N = `RSC_HOLD_CYC;
   localparam [3:0] DIV_N  = `RSC_WDOG_DIV - 1;

   function above_top;
      input [15:0] a;
      begin
         above_top = (a > `RSC_CODE_TOP);
      end
   endfunction

   wire       por_n_s;
   wire       pin_n_s;
   wire       above_s;
   wire       comp_s;
   wire       clk_s;
   wire       clk_timeout;

   reg  [2:0] state_q;
   reg  [3:0] hold_q;
   reg  [2:0] cause_q;
   reg  [2:0] last_q;
   reg        por_seen_q;
   reg        mon_on_q;
   reg        sel_mon_q;
   reg        sel_comp_q;
   reg        sel_clk_q;
   reg        soft_req_q;
   reg  [3:0] div_q;
   reg [15:0] wdog_cnt_q;
   reg        wdog_run_q;
   reg  [2:0] oe_dly_q;

   // Active-low inputs start at their idle level, so no false request follows reset
   rsc_sync #(.W(5), .INIT(5'h1e)) u_sync (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .async_i   ({por_n_i, rst_pin_n_i, supply_above_i, comparator_out_i, clk_level_i}),
      .sync_o    ({por_n_s, pin_n_s, above_s, comp_s, clk_s})
   );

   rsc_clk_watch u_watch (
      .ref_clk_i   (ref_clk_i),
      .rst_i       (rst_i),
      .enable_i    (sel_clk_q && state_q == ST_RUN),
      .clk_level_i (clk_s),
      .timeout_o   (clk_timeout)
   );

   wire wdog_fire = wdog_run_q && wdog_on_i && (wdog_cnt_q >= wdog_limit_i);
   wire flash_err = (flash_wr_i && program_store_write_on_i && above_top(flash_addr_i))
                  || (code_memory_read_i && above_top(code_addr_i))
                  || (branch_i && above_top(branch_addr_i))
                  || security_block_i
                  || (flash_wr_i && !mon_on_q);

   // The pin reads back our own drive through the synchroniser; ignore it while
   // driving and three cycles after, or the block would hold itself in reset.
   // An outside low inside that span is lost with it.
   wire pin_low = !pin_n_s && !rst_pin_oe_o && oe_dly_q == 3'b000;

   // Priority: power-on, monitor, pin, then internal sources
   reg [2:0] src;
   always @* begin
      src = `RSC_C_NONE;
      if (!por_n_s)
         src = `RSC_C_POWER;
      else if (mon_on_q && sel_mon_q && !above_s)
         src = `RSC_C_POWER;
      else if (pin_low)
         src = `RSC_C_PIN;
      else if (state_q == ST_RUN) begin
         if (sel_clk_q && clk_timeout)
            src = `RSC_C_CLKLOSS;
         else if (sel_comp_q && !comp_s)
            src = `RSC_C_COMP;
         else if (wdog_fire)
            src = `RSC_C_WDOG;
         else if (flash_err)
            src = `RSC_C_FLASH;
         else if (soft_req_q)
            src = `RSC_C_SOFT;
      end
   end

   wire wr_cause = sfr_wr_i && sfr_addr_i == `RSC_ADDR_CAUSE && state_q == ST_RUN;
   wire wr_mon   = sfr_wr_i && sfr_addr_i == `RSC_ADDR_MONCTL && state_q == ST_RUN;

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         state_q    <= ST_HOLD;
         hold_q     <= HOLD_N;
         cause_q    <= `RSC_C_POWER;
         last_q     <= `RSC_C_NONE;
         por_seen_q <= 1'b1;
         mon_on_q   <= `RSC_MON_ON_RST;
         sel_mon_q  <= 1'b0;
         sel_comp_q <= 1'b0;
         sel_clk_q  <= 1'b0;
         soft_req_q <= 1'b0;
      end else begin
         case (state_q)
            ST_RUN: begin
               if (src != `RSC_C_NONE) begin
                  state_q <= ST_HOLD;
                  hold_q  <= HOLD_N;
                  cause_q <= src;
               end
            end
            ST_HOLD: begin
               if (src == `RSC_C_POWER || src == `RSC_C_PIN) begin
                  hold_q <= HOLD_N;
                  if (cause_q != `RSC_C_POWER)
                     cause_q <= src;
               end else if (hold_q != 4'h0)
                  hold_q <= hold_q - 1'b1;
               else
                  state_q <= ST_EXIT;
            end
            ST_EXIT: begin
               state_q    <= ST_RUN;
               last_q     <= cause_q;
               por_seen_q <= 1'b0;
            end
            default: state_q <= ST_HOLD;
         endcase
         if (!por_n_s)
            por_seen_q <= 1'b1;
         if (!por_n_s)
            mon_on_q <= `RSC_MON_ON_RST;
         else if (wr_mon)
            mon_on_q <= sfr_wdata_i[`RSC_B_MON_ON];
         if (state_q == ST_HOLD) begin
            // Source selects return to reset values; the monitor select only on
            // a true power-on, so a monitor reset holds until the supply is back
            sel_comp_q <= 1'b0;
            sel_clk_q  <= 1'b0;
            soft_req_q <= 1'b0;
            if (por_seen_q)
               sel_mon_q <= 1'b0;
         end else if (wr_cause) begin
            sel_mon_q  <= sfr_wdata_i[`RSC_B_POWER];
            sel_clk_q  <= sfr_wdata_i[`RSC_B_CLKLOSS];
            sel_comp_q <= sfr_wdata_i[`RSC_B_COMP];
            soft_req_q <= sfr_wdata_i[`RSC_B_SOFT];
         end
      end
   end

   // Watchdog prescale and counter, restarted by every reset
   always @(posedge ref_clk_i) begin
      if (rst_i || state_q != ST_RUN) begin
         div_q       <= 4'h0;
         wdog_tick_o <= 1'b0;
         wdog_cnt_q  <= 16'h0000;
         wdog_run_q  <= 1'b1;
      end else begin
         wdog_tick_o <= (div_q == DIV_N);
         if (div_q == DIV_N)
            div_q <= 4'h0;
         else
            div_q <= div_q + 1'b1;
         if (wdog_kick_i)
            wdog_cnt_q <= 16'h0000;
         else if (div_q == DIV_N && wdog_cnt_q != 16'hffff)
            wdog_cnt_q <= wdog_cnt_q + 1'b1;
      end
   end

   function [7:0] flag_byte;
      input [2:0] c;
      begin
         flag_byte = 8'h00;
         case (c)
            `RSC_C_PIN:     flag_byte[`RSC_B_PIN]     = 1'b1;
            `RSC_C_POWER:   flag_byte[`RSC_B_POWER]   = 1'b1;
            `RSC_C_CLKLOSS: flag_byte[`RSC_B_CLKLOSS] = 1'b1;
            `RSC_C_WDOG:    flag_byte[`RSC_B_WDOG]    = 1'b1;
            `RSC_C_SOFT:    flag_byte[`RSC_B_SOFT]    = 1'b1;
            `RSC_C_COMP:    flag_byte[`RSC_B_COMP]    = 1'b1;
            `RSC_C_FLASH:   flag_byte[`RSC_B_FLASH]   = 1'b1;
            default:        flag_byte = 8'h00;
         endcase
      end
   endfunction

   // Read-modify-write reads the stored selects for the dual-purpose bits
   reg [7:0] cause_rd;
   always @* begin
      cause_rd = flag_byte(last_q);
      if (sfr_rmw_i) begin
         cause_rd[`RSC_B_POWER]   = sel_mon_q;
         cause_rd[`RSC_B_CLKLOSS] = sel_clk_q;
         cause_rd[`RSC_B_COMP]    = sel_comp_q;
         cause_rd[`RSC_B_SOFT]    = soft_req_q;
      end
   end

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         sfr_rdata_o         <= 8'h00;
         rst_pin_o           <= 1'b0;
         rst_pin_oe_o        <= 1'b1;
         oe_dly_q            <= 3'b111;
         core_rst_o          <= 1'b1;
         pc_clear_o          <= 1'b0;
         supply_monitor_on_o <= `RSC_MON_ON_RST;
      end else begin
         rst_pin_o  <= 1'b0;
         oe_dly_q   <= {oe_dly_q[1:0], rst_pin_oe_o};
         // Pin driven only for power-on and supply-monitor resets
         rst_pin_oe_o <= (state_q != ST_RUN && cause_q == `RSC_C_POWER)
                       || (src == `RSC_C_POWER);
         core_rst_o <= (state_q != ST_RUN) || (src != `RSC_C_NONE);
         pc_clear_o <= (state_q == ST_EXIT);
         supply_monitor_on_o <= mon_on_q;
         if (sfr_rd_i && sfr_addr_i == `RSC_ADDR_CAUSE)
            sfr_rdata_o <= cause_rd;
         else if (sfr_rd_i && sfr_addr_i == `RSC_ADDR_MONCTL)
            sfr_rdata_o <= {mon_on_q, above_s, 6'h00};
         else
            sfr_rdata_o <= 8'h00;
      end
   end
endmodule // rsc_reset_ctl

// ---- design/rsc_sync.v ----
`timescale 1ns/1ps
// Two-stage synchroniser for asynchronous level inputs
module rsc_sync #(
   parameter W = 1,
   parameter [W-1:0] INIT = {W{1'b0}}
) (
   input  wire         ref_clk_i,
   input  wire         rst_i,
   input  wire [W-1:0] async_i,
   output reg  [W-1:0] sync_o
);
   reg [W-1:0] meta_q;

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         meta_q <= INIT;
         sync_o <= INIT;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule // rsc_sync

// ---- testbench/rsc_ext_model.sv ----
`timescale 1ns/1ps
module rsc_ext_model (
   input  wire ext_low_i,
   input  wire supply_ok_i,
   input  wire comp_low_i,
   input  wire clk_stop_i,
   input  wire por_low_i,
   input  wire rst_pin_i,
   input  wire rst_pin_oe_i,
   output wire rst_pin_n_o,
   output wire supply_above_o,
   output wire comparator_out_o,
   output wire por_n_o,
   output reg  clk_level_o
);
   initial clk_level_o = 1'b0;
   // Watched clock, stopped while clk_stop_i is high, unrelated in phase to the block clock
   always #7 clk_level_o = clk_stop_i ? clk_level_o : ~clk_level_o;
   // Pull-up holds the pin high unless someone pulls it low
   assign rst_pin_n_o = !(ext_low_i || (rst_pin_oe_i && !rst_pin_i));
   assign supply_above_o = supply_ok_i;
   assign comparator_out_o = !comp_low_i;
   assign por_n_o = !por_low_i;
endmodule // rsc_ext_model

// ---- testbench/rsc_reset_ctl_props.sv ----
`timescale 1ns/1ps
module rsc_reset_ctl_props (
   input wire       ref_clk_i,
   input wire       rst_i,
   input wire       rst_pin_o,
   input wire       rst_pin_oe_o,
   input wire       supply_monitor_on_o,
   input wire       sfr_wr_i,
   input wire       sfr_rd_i,
   input wire [7:0] sfr_addr_i,
   input wire [7:0] sfr_wdata_i,
   input wire [7:0] sfr_rdata_o,
   input wire       core_rst_o,
   input wire       pc_clear_o,
   input wire       wdog_tick_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   wire soft_wr = sfr_wr_i && !core_rst_o && sfr_addr_i == 8'hef && sfr_wdata_i[4];
   wire mon_wr  = sfr_wr_i && !core_rst_o && sfr_addr_i == 8'hff;
   pin_low_a: assert property (rst_pin_o == 1'b0)
      else $error("reset pin output not low");
   exit_seq_a: assert property (pc_clear_o |-> core_rst_o ##1 (!core_rst_o && !pc_clear_o))
      else $error("reset exit sequence wrong");
   soft_rst_a: assert property (soft_wr |-> ##[1:3] core_rst_o)
      else $error("software reset not taken");
   soft_pin_a: assert property (soft_wr |=> !rst_pin_oe_o [*4])
      else $error("pin driven on software reset");
   mon_wr_a: assert property (mon_wr |-> ##2
      supply_monitor_on_o == $past(sfr_wdata_i[7], 2))
      else $error("monitor enable write lost");
   mon_por_a: assert property ($fell(rst_i) |-> supply_monitor_on_o)
      else $error("monitor not on after power-on");
   bit7_a: assert property (sfr_rd_i && sfr_addr_i == 8'hef |=> sfr_rdata_o[7] == 1'b0)
      else $error("cause bit 7 not zero");
   mon_rd_a: assert property (sfr_rd_i && sfr_addr_i == 8'hff
      |=> sfr_rdata_o[7] == $past(supply_monitor_on_o) && sfr_rdata_o[5:0] == 6'h00)
      else $error("monitor control read wrong");
   unmap_a: assert property (sfr_rd_i && sfr_addr_i != 8'hef && sfr_addr_i != 8'hff
      |=> sfr_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   tick_gap_a: assert property (wdog_tick_o |=> !wdog_tick_o [*8])
      else $error("watchdog ticks too close");
   soft_c: cover property (soft_wr ##[1:3] core_rst_o);
   pin_c: cover property (rst_pin_oe_o && core_rst_o);
   exit_c: cover property (pc_clear_o);
endmodule // rsc_reset_ctl_props

bind rsc_reset_ctl rsc_reset_ctl_props u_props (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
   .rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o), .supply_monitor_on_o(supply_monitor_on_o),
   .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
   .sfr_rdata_o(sfr_rdata_o), .core_rst_o(core_rst_o), .pc_clear_o(pc_clear_o),
   .wdog_tick_o(wdog_tick_o));

// ---- testbench/rsc_reset_ctl_tb.sv ----
`timescale 1ns/1ps
module rsc_reset_ctl_tb;
   reg         ref_clk = 1'b0;
   reg         rst = 1'b1;
   reg         ext_low = 0, supply_ok = 1, comp_low = 0, clk_stop = 0, por_low = 0;
   reg         wdog_on = 0, program_store_write_on = 0, fl_wr = 0, cm_rd = 0, br = 0, sec = 0;
   reg         wr = 0, rd = 0, rmw = 0;
   reg  [15:0] mem_addr = 16'h0000;
   reg  [7:0]  addr = 8'h00, wdata = 8'h00, rv;
   reg  [11:0] rows [0:10];
   wire        pin_n, sup, cmp, clv, por_n, pin_o, pin_oe, mon_on, core_rst, pc_clr, tick;
   wire [7:0]  rdata;
   integer     n_mismatch = 0, tests_run = 0, r;
   always #10 ref_clk = ~ref_clk;

   rsc_ext_model ext (.ext_low_i(ext_low), .supply_ok_i(supply_ok), .comp_low_i(comp_low),
      .clk_stop_i(clk_stop), .por_low_i(por_low), .rst_pin_i(pin_o), .rst_pin_oe_i(pin_oe),
      .rst_pin_n_o(pin_n), .supply_above_o(sup), .comparator_out_o(cmp), .por_n_o(por_n),
      .clk_level_o(clv));
   rsc_reset_ctl dut (.ref_clk_i(ref_clk), .rst_i(rst), .por_n_i(por_n), .rst_pin_n_i(pin_n),
      .rst_pin_o(pin_o), .rst_pin_oe_o(pin_oe), .supply_above_i(sup),
      .supply_monitor_on_o(mon_on), .comparator_out_i(cmp), .clk_level_i(clv),
      .wdog_kick_i(1'b0), .wdog_on_i(wdog_on), .wdog_limit_i(16'h0004), .flash_wr_i(fl_wr),
      .program_store_write_on_i(program_store_write_on), .flash_addr_i(mem_addr), .code_memory_read_i(cm_rd),
      .code_addr_i(mem_addr), .branch_i(br), .branch_addr_i(mem_addr),
      .security_block_i(sec), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rmw_i(rmw),
      .sfr_addr_i(addr), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .core_rst_o(core_rst),
      .pc_clear_o(pc_clr), .wdog_tick_o(tick));

   task chk(input [7:0] seen, input [7:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wreg(input [7:0] a, input [7:0] d);
      @(negedge ref_clk);
      wr = 1;
      addr = a;
      wdata = d;
      @(negedge ref_clk);
      wr = 0;
   endtask
   task rreg(input [7:0] a, input m);
      @(negedge ref_clk);
      rd = 1;
      rmw = m;
      addr = a;
      @(negedge ref_clk);
      rd = 0;
      rv = rdata;
   endtask
   // Bounded wait for the core reset level
   task wcore(input v);
      integer i;
      for (i = 0; i < 8000 && core_rst !== v; i = i + 1) @(negedge ref_clk);
      chk({7'h00, core_rst}, {7'h00, v});
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      // Nearly four times the expected run, clock-loss wait included
      #400000;
      n_mismatch = n_mismatch + 1;
      $display("watchdog expired");
      print_verdict;
   end

   initial begin
      // Row: action code, expected cause byte
      rows = '{12'h010, 12'h140, 12'h240, 12'h340, 12'h440, 12'h501,
               12'h620, 12'h704, 12'h808, 12'h902, 12'ha40};
      repeat (10) @(negedge ref_clk);
      rst = 0;
      wcore(0);
      rreg(8'hef, 0);
      chk(rv, 8'h02);
      for (r = 0; r < 11; r = r + 1) begin
         @(negedge ref_clk);
         mem_addr = 16'h7c00;
         case (rows[r][11:8])
            4'h0: wreg(8'hef, 8'h12);
            4'h1: {program_store_write_on, fl_wr} = 2'b11;
            4'h2: cm_rd = 1;
            4'h3: br = 1;
            4'h4: sec = 1;
            4'h5: ext_low = 1;
            4'h6: begin wreg(8'hef, 8'h22); comp_low = 1; end
            4'h7: begin wreg(8'hef, 8'h06); clk_stop = 1; end
            4'h8: wdog_on = 1;
            4'h9: begin wreg(8'hef, 8'h02); supply_ok = 0; end
            default: begin wreg(8'hff, 8'h00); mem_addr = 16'h0100; {program_store_write_on, fl_wr} = 2'b11; end
         endcase
         @(negedge ref_clk);
         {fl_wr, cm_rd, br, sec} = 4'h0;
         wcore(1);
         repeat (3) @(negedge ref_clk);
         chk({7'h00, pin_oe}, {7'h00, rows[r][11:8] == 4'h9});
         {ext_low, comp_low, clk_stop, wdog_on, program_store_write_on} = 5'h00;
         supply_ok = 1;
         wcore(0);
         rreg(8'hef, 0);
         chk(rv, rows[r][7:0]);
         $display("row %0d done", r);
      end
      wreg(8'hff, 8'h80);
      rreg(8'hff, 0);
      chk(rv, 8'hc0);
      wreg(8'hff, 8'h3f);
      rreg(8'hff, 0);
      chk(rv, 8'h40);
      wreg(8'hef, 8'h12);
      wcore(1);
      wcore(0);
      rreg(8'hff, 0);
      chk(rv, 8'h40);
      wreg(8'hef, 8'ha6);
      rreg(8'hef, 1);
      chk(rv, 8'h26);
      rreg(8'hef, 0);
      chk(rv, 8'h10);
      wreg(8'hef, 8'h02);
      por_low = 1;
      wcore(1);
      repeat (5) @(negedge ref_clk);
      por_low = 0;
      wcore(0);
      rreg(8'hef, 0);
      chk(rv, 8'h02);
      rreg(8'hff, 0);
      chk(rv, 8'hc0);
      r = 0;
      repeat (120) begin
         @(negedge ref_clk);
         if (tick === 1'b1) r = r + 1;
      end
      chk(r[7:0], 8'h0a);
      rreg(8'h10, 0);
      chk(rv, 8'h00);
      $display("hand tests done");
      print_verdict;
   end
endmodule // rsc_reset_ctl_tb
